/* ucrm_channel_regs.v */
// Register decode, interrupt logic and status of one asynchronous serial channel
//
// What this block does
// RULE1 - Each channel owns its registers, three address lines
// RULE2 - Offset 0: read receive byte, write transmit byte
// RULE3 - Divisor bit set, not 0xbf: divisor bytes
// RULE4 - Offset 1: interrupt enable, four low bits
// RULE5 - Interrupt status: FIFO bits, zeros, source code
// RULE6 - Offset 2 write: FIFO control fields
// RULE7 - Offset 3: line control byte
// RULE8 - Offset 4: modem control, five low bits
// RULE9 - Offset 5: read-only line status byte
// RULE10 - Offset 6: modem inputs and change flags
// RULE11 - Offset 7: scratch byte, no side effect
// RULE12 - Enable bits gate sources into interrupt status
// RULE13 - Receive interrupt follows FIFO level versus trigger
// RULE14 - Status code and interrupt clear together
// RULE15 - Data ready set on push, cleared when empty
// RULE16 - Trigger codes select 1, 4, 8, 14
// RULE17 - Status bit 0 low while interrupt pending
// RULE18 - Only highest-priority pending source is reported
// RULE19 - Host sets FIFO enable to change other fields
// RULE20 - Constant-zero bits ignore writes, read zero
// RULE21 - Writes to read-only locations change nothing
`timescale 1ns/1ps
`include "ucrm_map.vh"

module ucrm_channel_regs #(
    parameter FIFO_DEPTH = 16,
    parameter LVL_W = 5
) (
    input wire mclk,
    input wire resetn,
    input wire chan_sel_n,
    input wire [2:0] addr,
    input wire rd_n,
    input wire wr_n,
    input wire [7:0] wdata,
    output reg [7:0] rdata,
    output reg rdata_oe,
    input wire [7:0] rx_data,
    input wire rx_push,
    input wire [2:0] rx_err_tags,
    input wire rx_overrun,
    input wire rx_fifo_error,
    input wire rx_timeout,
    input wire tx_holding_empty,
    input wire tx_all_empty,
    input wire carrier_detect_in_n,
    input wire ring_indicator_in_n,
    input wire dsr_n,
    input wire cts_n,
    output reg [7:0] tx_data,
    output reg tx_write,
    output reg rx_pop,
    output reg rx_fifo_clear,
    output reg tx_fifo_clear,
    output reg [15:0] divisor,
    output reg [7:0] line_control,
    output reg fifo_enabled,
    output reg dma_mode,
    output reg loopback,
    output reg rts_n,
    output reg dtr_n,
    output reg spare_output_one_n,
    output reg irq
);

    localparam SW = 18;

    // Pin side: bus strobes, address, data and modem inputs
    wire [SW-1:0] pin_in;
    reg [SW-1:0] pin_meta;
    reg [SW-1:0] pin_sync;
    reg rd_prev;
    reg wr_prev;

    // Register state
    reg [7:0] interrupt_enable;
    reg [7:0] modem_control;
    reg [7:0] scratch_byte;
    reg [1:0] trig_sel;
    reg [LVL_W-1:0] rx_level;
    reg [LVL_W-1:0] next_rx_level;
    reg overrun_flag;
    reg txrdy_flag;
    reg tx_empty_prev;
    reg [3:0] modem_prev;
    reg [3:0] modem_delta;

    // Decoded bus events
    wire sel;
    wire rd_start;
    wire wr_start;
    wire [2:0] bus_addr;
    wire [7:0] bus_wdata;
    wire div_access;
    wire hidden_access;
    wire [3:0] modem_now;
    wire data_ready;
    wire [LVL_W-1:0] trig_level;
    wire [7:0] line_status;
    wire [7:0] modem_status;
    wire [7:0] interrupt_status;
    wire [3:0] mctl_loop;
    wire rx_data_pend;

    reg [3:0] int_code;
    reg [7:0] read_mux;

    assign pin_in = {chan_sel_n, rd_n, wr_n, addr, wdata,
                     carrier_detect_in_n, ring_indicator_in_n, dsr_n, cts_n};

    // Two-stage synchroniser per pin; only the second stage is read
    genvar gi;
    generate
        for (gi = 0; gi < SW; gi = gi + 1) begin : g_sync
            always @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    pin_meta[gi] <= 1'b1;
                    pin_sync[gi] <= 1'b1;
                end else begin
                    pin_meta[gi] <= pin_in[gi];
                    pin_sync[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate

    // Strobe history for edge detection
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rd_prev <= 1'b1;
            wr_prev <= 1'b1;
        end else begin
            rd_prev <= pin_sync[16];
            wr_prev <= pin_sync[15];
        end
    end

    // Accesses count only while this channel is selected
    assign sel = ~pin_sync[17]; // RULE1
    assign rd_start = sel & ~pin_sync[16] & rd_prev;
    assign wr_start = sel & ~pin_sync[15] & wr_prev;
    assign bus_addr = pin_sync[14:12];
    assign bus_wdata = pin_sync[11:4];

    // Divisor latch window; the 0xbf value opens a set this block lacks
    assign div_access = line_control[`UCRM_LINE_DIV_BIT] &
                        (line_control != `UCRM_LINE_HIDE_DIV); // RULE3
    assign hidden_access = line_control == `UCRM_LINE_HIDE_DIV;

    // Loopback feeds modem outputs back as inputs: carrier, ring, set-ready, clear-to-send
    assign mctl_loop = {modem_control[`UCRM_MCTL_INT_EN], modem_control[`UCRM_MCTL_OUT1],
                        modem_control[`UCRM_MCTL_DTR], modem_control[`UCRM_MCTL_RTS]};
    assign modem_now = modem_control[`UCRM_MCTL_LOOP] ? mctl_loop : ~pin_sync[3:0];

    // Trigger level lookup
    assign trig_level = (trig_sel == 2'h0) ? `UCRM_TRIG_LVL0 :
                        (trig_sel == 2'h1) ? `UCRM_TRIG_LVL1 :
                        (trig_sel == 2'h2) ? `UCRM_TRIG_LVL2 :
                        `UCRM_TRIG_LVL3; // RULE16

    assign data_ready = rx_level != {LVL_W{1'b0}}; // RULE15

    // Line status; error tags belong to the character at the head
    assign line_status = {rx_fifo_error & fifo_enabled,
                          tx_all_empty, tx_holding_empty,
                          rx_err_tags & {3{data_ready}},
                          overrun_flag, data_ready}; // RULE9

    assign modem_status = {modem_now, modem_delta}; // RULE10

    // Receive-data source: trigger level in FIFO mode, any byte otherwise
    assign rx_data_pend = fifo_enabled ? (rx_level >= trig_level) : data_ready; // RULE13

    // Highest-priority enabled source wins; the rest stay pending
    always @* begin
        if (interrupt_enable[`UCRM_IEN_LINE] & (overrun_flag | (|line_status[4:2]))) begin
            int_code = `UCRM_SRC_LINE; // RULE18
        end else if (interrupt_enable[`UCRM_IEN_RXDATA] & rx_timeout & data_ready) begin
            int_code = `UCRM_SRC_TIMEOUT;
        end else if (interrupt_enable[`UCRM_IEN_RXDATA] & rx_data_pend) begin
            int_code = `UCRM_SRC_RXDATA; // RULE12 RULE14
        end else if (interrupt_enable[`UCRM_IEN_TXEMPTY] & txrdy_flag) begin
            int_code = `UCRM_SRC_TXRDY;
        end else if (interrupt_enable[`UCRM_IEN_MODEM] & (|modem_delta)) begin
            int_code = `UCRM_SRC_MODEM;
        end else begin
            int_code = `UCRM_SRC_NONE; // RULE17
        end
    end

    assign interrupt_status = {fifo_enabled, fifo_enabled, 2'b00, int_code}; // RULE5

    // Read multiplexer; reserved bits are forced to zero here
    always @* begin
        case (bus_addr)
            `UCRM_OFS_HOLDING: begin
                if (hidden_access) begin
                    read_mux = 8'h00;
                end else if (div_access) begin
                    read_mux = divisor[7:0]; // RULE3
                end else begin
                    read_mux = rx_data; // RULE2
                end
            end
            `UCRM_OFS_ENABLE: begin
                if (hidden_access) begin
                    read_mux = 8'h00;
                end else if (div_access) begin
                    read_mux = divisor[15:8];
                end else begin
                    read_mux = interrupt_enable & `UCRM_IEN_MASK; // RULE4 RULE20
                end
            end
            `UCRM_OFS_STATUS: read_mux = interrupt_status;
            `UCRM_OFS_LINE_CTRL: read_mux = line_control; // RULE7
            `UCRM_OFS_MODEM_CTRL: read_mux = modem_control & `UCRM_MCTL_MASK; // RULE8 RULE20
            `UCRM_OFS_LINE_STAT: read_mux = line_status;
            `UCRM_OFS_MODEM_STAT: read_mux = modem_status;
            `UCRM_OFS_SCRATCH: read_mux = scratch_byte; // RULE11
            default: read_mux = 8'h00;
        endcase
    end

    // Receive level count; non-FIFO mode holds a single character
    always @* begin
        next_rx_level = rx_level;
        // A push and a pop in one cycle leave the count as it is
        if (rx_push & ~(rx_pop & data_ready) &
            (rx_level < (fifo_enabled ? FIFO_DEPTH[LVL_W-1:0] : {{(LVL_W-1){1'b0}}, 1'b1}))) begin
            next_rx_level = rx_level + {{(LVL_W-1){1'b0}}, 1'b1};
        end else if (rx_pop & data_ready & ~rx_push) begin
            next_rx_level = rx_level - {{(LVL_W-1){1'b0}}, 1'b1};
        end
    end

    // Read side: latch data, pop the receive byte, drive the bus
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 8'h00;
            rdata_oe <= 1'b0;
            rx_pop <= 1'b0;
        end else begin
            rdata_oe <= sel & ~pin_sync[16];
            rx_pop <= rd_start & (bus_addr == `UCRM_OFS_HOLDING) &
                      ~div_access & ~hidden_access & data_ready;
            if (rd_start) begin
                rdata <= read_mux;
            end
        end
    end

    // Level counter; a receive FIFO reset empties it at once
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rx_level <= {LVL_W{1'b0}};
        end else if (rx_fifo_clear) begin
            rx_level <= {LVL_W{1'b0}};
        end else begin
            rx_level <= next_rx_level; // RULE15
        end
    end

    // Write side: control registers and one-cycle strobes
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            interrupt_enable <= `UCRM_RST_IEN;
            line_control <= `UCRM_RST_LINE;
            modem_control <= `UCRM_RST_MCTL;
            scratch_byte <= `UCRM_RST_SCRATCH;
            divisor <= `UCRM_RST_DIVISOR;
            trig_sel <= `UCRM_RST_TRIG;
            fifo_enabled <= 1'b0;
            dma_mode <= 1'b0;
            tx_data <= 8'h00;
            tx_write <= 1'b0;
            rx_fifo_clear <= 1'b0;
            tx_fifo_clear <= 1'b0;
        end else begin
            tx_write <= 1'b0;
            rx_fifo_clear <= 1'b0;
            tx_fifo_clear <= 1'b0;
            if (wr_start) begin
                case (bus_addr)
                    `UCRM_OFS_HOLDING: begin
                        if (div_access) begin
                            divisor[7:0] <= bus_wdata; // RULE3
                        end else if (!hidden_access) begin
                            tx_data <= bus_wdata; // RULE2
                            tx_write <= 1'b1;
                        end
                    end
                    `UCRM_OFS_ENABLE: begin
                        if (div_access) begin
                            divisor[15:8] <= bus_wdata;
                        end else if (!hidden_access) begin
                            interrupt_enable <= bus_wdata & `UCRM_IEN_MASK; // RULE4 RULE20
                        end
                    end
                    `UCRM_OFS_STATUS: begin
                        fifo_enabled <= bus_wdata[`UCRM_FCTL_ENABLE]; // RULE6
                        if (bus_wdata[`UCRM_FCTL_ENABLE]) begin
                            trig_sel <= bus_wdata[`UCRM_FCTL_TRIG_HI:`UCRM_FCTL_TRIG_LO]; // RULE19
                            dma_mode <= bus_wdata[`UCRM_FCTL_DMA];
                            rx_fifo_clear <= bus_wdata[`UCRM_FCTL_RX_RESET];
                            tx_fifo_clear <= bus_wdata[`UCRM_FCTL_TX_RESET];
                        end
                    end
                    `UCRM_OFS_LINE_CTRL: line_control <= bus_wdata; // RULE7
                    `UCRM_OFS_MODEM_CTRL: modem_control <= bus_wdata & `UCRM_MCTL_MASK; // RULE8
                    `UCRM_OFS_SCRATCH: scratch_byte <= bus_wdata; // RULE11
                    // Status locations hold nothing writable
                    default: scratch_byte <= scratch_byte; // RULE21
                endcase
            end
        end
    end

    // Overrun flag: set wins over the clear by a status read
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            overrun_flag <= 1'b0;
        end else if (rx_overrun) begin
            overrun_flag <= 1'b1;
        end else if (rd_start & (bus_addr == `UCRM_OFS_LINE_STAT)) begin
            overrun_flag <= 1'b0;
        end
    end

    // Transmit-ready flag: raised on emptying or on enabling while empty
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tx_empty_prev <= 1'b1; // Idle level, so no false edge follows reset
            txrdy_flag <= 1'b0;
        end else begin
            tx_empty_prev <= tx_holding_empty;
            if ((tx_holding_empty & ~tx_empty_prev) |
                (wr_start & (bus_addr == `UCRM_OFS_ENABLE) & ~div_access & ~hidden_access &
                 bus_wdata[`UCRM_IEN_TXEMPTY] & ~interrupt_enable[`UCRM_IEN_TXEMPTY] &
                 tx_holding_empty)) begin
                txrdy_flag <= 1'b1;
            end else if ((rd_start & (bus_addr == `UCRM_OFS_STATUS) &
                          (int_code == `UCRM_SRC_TXRDY)) | tx_write) begin
                txrdy_flag <= 1'b0;
            end
        end
    end

    // Modem change flags; a change in the read cycle is kept
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            modem_prev <= 4'h0;
            modem_delta <= 4'h0;
        end else begin
            modem_prev <= modem_now;
            if (rd_start & (bus_addr == `UCRM_OFS_MODEM_STAT)) begin
                modem_delta <= modem_now ^ modem_prev; // RULE10
            end else begin
                modem_delta <= modem_delta | (modem_now ^ modem_prev);
            end
        end
    end

    // Modem pins go inactive in loopback; interrupt pin gated by enable bit
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            loopback <= 1'b0;
            rts_n <= 1'b1;
            dtr_n <= 1'b1;
            spare_output_one_n <= 1'b1;
            irq <= 1'b0;
        end else begin
            loopback <= modem_control[`UCRM_MCTL_LOOP];
            rts_n <= ~modem_control[`UCRM_MCTL_RTS] | modem_control[`UCRM_MCTL_LOOP];
            dtr_n <= ~modem_control[`UCRM_MCTL_DTR] | modem_control[`UCRM_MCTL_LOOP];
            spare_output_one_n <= ~modem_control[`UCRM_MCTL_OUT1] |
                                  modem_control[`UCRM_MCTL_LOOP];
            irq <= ~int_code[0] & modem_control[`UCRM_MCTL_INT_EN]; // RULE12 RULE13
        end
    end

endmodule // ucrm_channel_regs

/* ucrm_map.vh */
// Register offsets, field positions, reset values and codes of one serial channel
`ifndef UCRM_MAP_VH
`define UCRM_MAP_VH

// Register offsets on the three address lines
`define UCRM_OFS_HOLDING 3'h0
`define UCRM_OFS_ENABLE 3'h1
`define UCRM_OFS_STATUS 3'h2
`define UCRM_OFS_LINE_CTRL 3'h3
`define UCRM_OFS_MODEM_CTRL 3'h4
`define UCRM_OFS_LINE_STAT 3'h5
`define UCRM_OFS_MODEM_STAT 3'h6
`define UCRM_OFS_SCRATCH 3'h7

// Line control value that hides the divisor latch
`define UCRM_LINE_HIDE_DIV 8'hbf
`define UCRM_LINE_DIV_BIT 7

// Field positions
`define UCRM_IEN_RXDATA 0
`define UCRM_IEN_TXEMPTY 1
`define UCRM_IEN_LINE 2
`define UCRM_IEN_MODEM 3
`define UCRM_FCTL_ENABLE 0
`define UCRM_FCTL_RX_RESET 1
`define UCRM_FCTL_TX_RESET 2
`define UCRM_FCTL_DMA 3
`define UCRM_FCTL_TRIG_HI 7
`define UCRM_FCTL_TRIG_LO 6
`define UCRM_MCTL_DTR 0
`define UCRM_MCTL_RTS 1
`define UCRM_MCTL_OUT1 2
`define UCRM_MCTL_INT_EN 3
`define UCRM_MCTL_LOOP 4

// Writable field masks; bits outside them read zero
`define UCRM_IEN_MASK 8'h0f
`define UCRM_MCTL_MASK 8'h1f

// Reset values
`define UCRM_RST_IEN 8'h00
`define UCRM_RST_LINE 8'h00
`define UCRM_RST_MCTL 8'h00
`define UCRM_RST_SCRATCH 8'h00
`define UCRM_RST_DIVISOR 16'h0001
`define UCRM_RST_TRIG 2'h0

// Receive trigger levels for select codes 00, 01, 10, 11
`define UCRM_TRIG_LVL0 5'h01
`define UCRM_TRIG_LVL1 5'h04
`define UCRM_TRIG_LVL2 5'h08
`define UCRM_TRIG_LVL3 5'h0e

// Interrupt status source codes, bits 3:0
`define UCRM_SRC_LINE 4'h6
`define UCRM_SRC_TIMEOUT 4'hc
`define UCRM_SRC_RXDATA 4'h4
`define UCRM_SRC_TXRDY 4'h2
`define UCRM_SRC_MODEM 4'h0
`define UCRM_SRC_NONE 4'h1

`endif

/* ucrm_channel_regs_props.sv */
// Port-level checker of the serial channel register block
`timescale 1ns/1ps
module ucrm_channel_regs_props (
    input wire mclk,
    input wire resetn,
    input wire chan_sel_n,
    input wire [2:0] addr,
    input wire rd_n,
    input wire wr_n,
    input wire [7:0] wdata,
    input wire rdata_oe,
    input wire [7:0] tx_data,
    input wire tx_write,
    input wire rx_pop,
    input wire rx_fifo_clear,
    input wire tx_fifo_clear,
    input wire dma_mode,
    input wire [15:0] divisor,
    input wire [7:0] line_control,
    input wire fifo_enabled,
    input wire loopback,
    input wire rts_n,
    input wire dtr_n,
    input wire spare_output_one_n,
    input wire irq
);
    // Pins pass two flops, so every cause lies three samples back
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    AST_TX_PULSE: assert property (tx_write |-> !$past(wr_n, 3) && $past(addr, 3) == 3'h0
        && !line_control[7] ##1 !tx_write) else $error("transmit pulse without its write");
    AST_TX_DATA: assert property (tx_write |-> tx_data == $past(wdata, 3))
        else $error("transmit byte differs from bus data");
    AST_RD_LATENCY: assert property ($rose(rdata_oe) |-> !$past(rd_n, 3) && $past(rd_n, 4)
        && !$past(chan_sel_n, 3)) else $error("read answer at wrong edge");
    AST_RD_RELEASE: assert property ($rose(rd_n) |-> ##[1:4] !rdata_oe)
        else $error("bus driver left on after read");
    AST_POP_SRC: assert property (rx_pop |-> !$past(rd_n, 3) && $past(addr, 3) == 3'h0
        ##1 !rx_pop) else $error("receive pop without a byte read");
    AST_CLR_EN: assert property (rx_fifo_clear |-> fifo_enabled ##1 !rx_fifo_clear)
        else $error("receive clear while queues off");
    AST_TXCLR_EN: assert property (tx_fifo_clear |-> fifo_enabled ##1 !tx_fifo_clear)
        else $error("transmit clear while queues off");
    AST_DMA_SRC: assert property ($changed(dma_mode) |-> !$past(wr_n, 3) && fifo_enabled
        && $past(addr, 3) == 3'h2) else $error("transfer mode changed without enabled write");
    AST_LINE_SRC: assert property ($changed(line_control) |-> !$past(wr_n, 3)
        && $past(addr, 3) == 3'h3) else $error("line control changed without write");
    AST_DIV_SRC: assert property ($changed(divisor) |-> !$past(wr_n, 3) && line_control[7]
        && line_control != 8'hbf && $past(addr, 3) <= 3'h1) else $error("divisor changed badly");
    AST_FE_SRC: assert property ($changed(fifo_enabled) |-> !$past(wr_n, 3)
        && $past(addr, 3) == 3'h2) else $error("queue enable changed without write");
    AST_LOOP_OUT: assert property (loopback && $past(loopback) |-> rts_n && dtr_n
        && spare_output_one_n) else $error("modem outputs active in loopback");
    COV_TX: cover property (tx_write);
    COV_POP: cover property (rx_pop);
    COV_CLR: cover property (rx_fifo_clear);
    COV_IRQ: cover property ($rose(irq));
endmodule // ucrm_channel_regs_props

bind ucrm_channel_regs ucrm_channel_regs_props u_props (.mclk(mclk), .resetn(resetn),
    .chan_sel_n(chan_sel_n), .addr(addr), .rd_n(rd_n), .wr_n(wr_n), .wdata(wdata),
    .rdata_oe(rdata_oe), .tx_data(tx_data), .tx_write(tx_write), .rx_pop(rx_pop),
    .rx_fifo_clear(rx_fifo_clear), .divisor(divisor), .line_control(line_control),
    .tx_fifo_clear(tx_fifo_clear), .dma_mode(dma_mode),
    .fifo_enabled(fifo_enabled), .loopback(loopback), .rts_n(rts_n), .dtr_n(dtr_n),
    .spare_output_one_n(spare_output_one_n), .irq(irq));

/* ucrm_host.sv */
// Host processor model on the channel's parallel bus
`timescale 1ns/1ps
module ucrm_host (
    input wire mclk,
    output logic chan_sel_n,
    output logic [2:0] addr,
    output logic rd_n,
    output logic wr_n,
    output logic [7:0] wdata,
    input wire [7:0] rdata,
    input wire rdata_oe
);
    initial begin
        chan_sel_n = 1'b1;
        addr = 3'h0;
        rd_n = 1'b1;
        wr_n = 1'b1;
        wdata = 8'h00;
    end
    // One access; address settles three edges before the strobe because the pins are synced
    task automatic acc(input bit w, input [2:0] a, input [7:0] d, output [7:0] q);
        int n;
        n = 0;
        @(posedge mclk);
        chan_sel_n <= 1'b0;
        addr <= a;
        wdata <= d;
        repeat (3) @(posedge mclk);
        if (w) wr_n <= 1'b0;
        else rd_n <= 1'b0;
        repeat (4) @(posedge mclk);
        while (!w && rdata_oe !== 1'b1 && n < 8) begin
            @(posedge mclk);
            n++;
        end
        q = rdata;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        repeat (4) @(posedge mclk);
        // Released lines show the inverse so stale values cannot pass
        chan_sel_n <= 1'b1;
        addr <= ~a;
        wdata <= ~d;
        @(posedge mclk);
    endtask
endmodule // ucrm_host

/* tb_uart_channel_register_map.sv */
// Self-checking bench for the serial channel register block
`timescale 1ns/1ps
module tb_uart_channel_register_map;
    logic mclk = 1'b0, resetn = 1'b0, rx_push = 1'b0;
    logic car_n = 1'b1, ring_n = 1'b1, dsr_n = 1'b1, cts_n = 1'b1, rx_ovr = 1'b0, rx_tmo = 1'b0;
    logic [7:0] rx_data = 8'h00, rxb, v, q;
    logic [2:0] rx_err_tags = 3'h0, addr;
    logic chan_sel_n, rd_n, wr_n, rdata_oe, tx_write, rx_pop, fifo_enabled, loopback;
    logic rts_n, dtr_n, spare_n, irq, dma_mode;
    logic [7:0] wdata, rdata, tx_data, line_control;
    logic [15:0] divisor;
    int error_cnt = 0, tests_run = 0, tx_cnt = 0;

    ucrm_host u_host (.mclk(mclk), .chan_sel_n(chan_sel_n), .addr(addr), .rd_n(rd_n),
        .wr_n(wr_n), .wdata(wdata), .rdata(rdata), .rdata_oe(rdata_oe));
    // Transmit side held empty and FIFO error quiet; both lie outside this bench's scope
    ucrm_channel_regs u_dut (.mclk(mclk), .resetn(resetn), .chan_sel_n(chan_sel_n),
        .addr(addr), .rd_n(rd_n), .wr_n(wr_n), .wdata(wdata), .rdata(rdata),
        .rdata_oe(rdata_oe), .rx_data(rx_data), .rx_push(rx_push),
        .rx_err_tags(rx_err_tags), .rx_overrun(rx_ovr), .rx_fifo_error(1'b0),
        .rx_timeout(rx_tmo), .tx_holding_empty(1'b1), .tx_all_empty(1'b1),
        .carrier_detect_in_n(car_n), .ring_indicator_in_n(ring_n), .dsr_n(dsr_n),
        .cts_n(cts_n), .tx_data(tx_data), .tx_write(tx_write), .rx_pop(rx_pop),
        .rx_fifo_clear(), .tx_fifo_clear(), .divisor(divisor),
        .line_control(line_control), .fifo_enabled(fifo_enabled), .dma_mode(dma_mode),
        .loopback(loopback), .rts_n(rts_n), .dtr_n(dtr_n), .spare_output_one_n(spare_n),
        .irq(irq));

    // Clock and transmit pulse counter
    always #20 mclk = ~mclk;
    always @(posedge mclk) if (tx_write === 1'b1) tx_cnt++;

    function automatic [7:0] trig(input [1:0] c);
        trig = (c == 2'h0) ? 8'h01 : (c == 2'h1) ? 8'h04 : (c == 2'h2) ? 8'h08 : 8'h0e;
    endfunction
    task automatic chk8(input [7:0] g, input [7:0] e);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input [2:0] a, input [7:0] d);
        logic [7:0] r;
        u_host.acc(1'b1, a, d, r);
    endtask
    task automatic rdr(input [2:0] a, input [7:0] e);
        logic [7:0] r;
        u_host.acc(1'b0, a, 8'h00, r);
        chk8(r, e);
    endtask
    task automatic push;
        rx_push <= 1'b1;
        @(posedge mclk);
        rx_push <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic done(input string s);
        $display("Test %s finished", s);
    endtask
    task automatic conclude;
        $display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Watchdog well beyond the thousand or so cycles the tests need
    initial begin
        #2000000;
        error_cnt++;
        conclude();
    end

    initial begin
        void'($urandom(76));
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        rdr(3'h1, 8'h00);
        rdr(3'h2, 8'h01);
        rdr(3'h3, 8'h00);
        rdr(3'h4, 8'h00);
        rdr(3'h7, 8'h00);
        chk8({rts_n, dtr_n, spare_n, 5'h00}, 8'he0);
        done("reset");
        // Scratch keeps random bytes; writes to status places change nothing
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom);
            wr(3'h7, v);
            wr(3'h5, ~v);
            wr(3'h6, ~v);
            rdr(3'h7, v);
        end
        done("scratch");
        wr(3'h1, 8'hff);
        rdr(3'h1, 8'h0f);
        rdr(3'h2, 8'h02);
        wr(3'h4, 8'hff);
        rdr(3'h4, 8'h1f);
        chk8({7'h00, loopback & rts_n & dtr_n}, 8'h01);
        v = 8'($urandom) & 8'h7f;
        wr(3'h3, v);
        rdr(3'h3, v);
        done("fields");
        wr(3'h3, 8'h80);
        v = 8'($urandom);
        wr(3'h0, v);
        wr(3'h1, ~v);
        rdr(3'h0, v);
        rdr(3'h1, ~v);
        wr(3'h3, 8'hbf);
        wr(3'h0, 8'h5a);
        rdr(3'h0, 8'h00);
        chk8(divisor[7:0], v);
        wr(3'h3, 8'h03);
        wr(3'h0, ~v);
        chk8(tx_data, ~v);
        chk8(8'(tx_cnt), 8'h01);
        done("divisor");
        // Each trigger code: one short of the level stays quiet, the level raises the source
        wr(3'h1, 8'h01);
        for (int c = 0; c < 4; c++) begin
            rxb = 8'($urandom);
            rx_data <= rxb;
            wr(3'h2, {c[1:0], 6'h03});
            for (int k = 1; k < trig(c[1:0]); k++) push();
            rdr(3'h2, 8'hc1);
            push();
            rdr(3'h2, 8'hc4);
            rdr(3'h5, 8'h61);
            rdr(3'h0, rxb);
            rdr(3'h2, 8'hc1);
        end
        done("trigger");
        wr(3'h2, 8'h0f);
        wr(3'h1, 8'h05);
        wr(3'h4, 8'h08);
        rx_err_tags <= 3'h4;
        push();
        rdr(3'h2, 8'hc6);
        chk8({7'h00, irq}, 8'h01);
        rdr(3'h5, 8'h71);
        rx_err_tags <= 3'h0;
        rdr(3'h2, 8'hc4);
        rx_tmo <= 1'b1;
        rdr(3'h2, 8'hcc);
        rx_tmo <= 1'b0;
        rdr(3'h0, rxb);
        rdr(3'h2, 8'hc1);
        chk8({7'h00, irq}, 8'h00);
        rx_ovr <= 1'b1;
        @(posedge mclk);
        rx_ovr <= 1'b0;
        rdr(3'h2, 8'hc6);
        rdr(3'h5, 8'h62);
        rdr(3'h2, 8'hc1);
        wr(3'h2, 8'hc0);
        chk8({6'h00, dma_mode, fifo_enabled}, 8'h02);
        rdr(3'h2, 8'h01);
        done("priority");
        u_host.acc(1'b0, 3'h6, 8'h00, q);
        v = 8'($urandom) | 8'h01;
        {car_n, ring_n, dsr_n, cts_n} <= {car_n, ring_n, dsr_n, cts_n} ^ v[3:0];
        repeat (4) @(posedge mclk);
        u_host.acc(1'b0, 3'h6, 8'h00, q);
        chk8(q & 8'h0f, {4'h0, v[3:0]});
        chk8(q & 8'hf0, {~{car_n, ring_n, dsr_n, cts_n}, 4'h0});
        u_host.acc(1'b0, 3'h6, 8'h00, q);
        chk8(q & 8'h0f, 8'h00);
        done("modem");
        conclude();
    end
endmodule // tb_uart_channel_register_map
